// file: include/out_router_defs.vh
`ifndef OUT_ROUTER_DEFS_VH
`define OUT_ROUTER_DEFS_VH

// Register byte addresses
`define ADDR_TERM_FUNC0   12'h000
`define ADDR_TERM_FUNC4   12'h010
`define ADDR_RELAY_FUNC   12'h014
`define ADDR_TERM_ACT0    12'h018
`define ADDR_TERM_ACT4    12'h028
`define ADDR_RELAY_ACT    12'h02c
`define ADDR_ALARM_MODE   12'h030
`define ADDR_STATUS       12'h034
`define ADDR_OUTPUTS      12'h038

// Reset values
`define RST_FUNC          8'h00
`define RST_TERM_ACT      8'h00
`define RST_RELAY_ACT     8'h01
`define RST_ALARM_MODE    8'h00

// Active-state and alarm code mode values
`define ACT_NO            8'h00
`define ACT_NC            8'h01
`define ALARM_MODE_OFF    8'h00
`define ALARM_MODE_3BIT   8'h01
`define ALARM_MODE_4BIT   8'h02

// Function codes
`define FN_RUN            8'h00
`define FN_CONST_SPEED    8'h01
`define FN_FREQ_OVER      8'h02
`define FN_OVERLOAD1      8'h03
`define FN_PID_DEV        8'h04
`define FN_FAULT          8'h05
`define FN_FREQ_REACH     8'h06
`define FN_OVERTORQUE     8'h07
`define FN_POWER_DIP      8'h08
`define FN_LOW_SUPPLY     8'h09
`define FN_TORQUE_LIM     8'h0a
`define FN_RUN_TIME       8'h0b
`define FN_ON_TIME        8'h0c
`define FN_THERMAL        8'h0d
`define FN_BRAKE_REL      8'h13
`define FN_BRAKE_ERR      8'h14
`define FN_ZERO_SPEED     8'h15
`define FN_SPEED_DEV      8'h16
`define FN_POS_DONE       8'h17
`define FN_FREQ_OVER2     8'h18
`define FN_FREQ_REACH2    8'h19
`define FN_OVERLOAD2      8'h1a
`define FN_ANALOG_LOST0   8'h1b
`define FN_ANALOG_LOST2   8'h1d
`define FN_PID_FB_CMP     8'h1f
`define FN_COMM_LOST      8'h20
`define FN_LOGIC_FIRST    8'h21
`define FN_LOGIC_LAST     8'h26
`define FN_CAP_LIFE       8'h27
`define FN_FAN_DROP       8'h28
`define FN_START_CONTACT  8'h29
`define FN_HEATSINK_HOT   8'h2a
`define FN_LOW_CURRENT    8'h2b
`define FN_GENOUT_FIRST   8'h2c
`define FN_GENOUT_LAST    8'h31
`define FN_DRIVE_READY    8'h32
`define FN_FWD_ROT        8'h33
`define FN_REV_ROT        8'h34
`define FN_MAJOR_FAIL     8'h35

// Status vector layout: bit index of each routed flag
`define ST_WIDTH          48
`define ST_RUN            0
`define ST_CONST_SPEED    1
`define ST_FREQ_OVER      2
`define ST_OVERLOAD1      3
`define ST_PID_DEV        4
`define ST_FAULT          5
`define ST_FREQ_REACH     6
`define ST_OVERTORQUE     7
`define ST_POWER_DIP      8
`define ST_LOW_SUPPLY     9
`define ST_TORQUE_LIM     10
`define ST_RUN_TIME       11
`define ST_ON_TIME        12
`define ST_THERMAL        13
`define ST_BRAKE_REL      14
`define ST_BRAKE_ERR      15
`define ST_ZERO_SPEED     16
`define ST_SPEED_DEV      17
`define ST_POS_DONE       18
`define ST_FREQ_OVER2     19
`define ST_FREQ_REACH2    20
`define ST_OVERLOAD2      21
`define ST_ANALOG_LOST0   22
`define ST_PID_FB_CMP     25
`define ST_COMM_LOST      26
`define ST_LOGIC0         27
`define ST_CAP_LIFE       33
`define ST_FAN_DROP       34
`define ST_START_CONTACT  35
`define ST_HEATSINK_HOT   36
`define ST_LOW_CURRENT    37
`define ST_GENOUT0        38
`define ST_DRIVE_READY    44
`define ST_FWD_ROT        45
`define ST_REV_ROT        46
`define ST_MAJOR_FAIL     47

`endif

// file: src/signal_selector.v
`timescale 1ns/100ps
`include "out_router_defs.vh"

module signal_selector
(
    // Selection
    input  wire [7:0]               func_i,
    input  wire [`ST_WIDTH-1:0]     status_i,
    // Result
    output reg                      sel_o
);

    always @*
    begin
        sel_o = 1'b0;
        case (func_i)
            `FN_RUN:           sel_o = status_i[`ST_RUN];
            `FN_CONST_SPEED:   sel_o = status_i[`ST_CONST_SPEED];
            `FN_FREQ_OVER:     sel_o = status_i[`ST_FREQ_OVER];
            `FN_OVERLOAD1:     sel_o = status_i[`ST_OVERLOAD1];
            `FN_PID_DEV:       sel_o = status_i[`ST_PID_DEV];
            `FN_FAULT:         sel_o = status_i[`ST_FAULT];
            `FN_FREQ_REACH:    sel_o = status_i[`ST_FREQ_REACH];
            `FN_OVERTORQUE:    sel_o = status_i[`ST_OVERTORQUE];
            `FN_POWER_DIP:     sel_o = status_i[`ST_POWER_DIP];
            `FN_LOW_SUPPLY:    sel_o = status_i[`ST_LOW_SUPPLY];
            `FN_TORQUE_LIM:    sel_o = status_i[`ST_TORQUE_LIM];
            `FN_RUN_TIME:      sel_o = status_i[`ST_RUN_TIME];
            `FN_ON_TIME:       sel_o = status_i[`ST_ON_TIME];
            `FN_THERMAL:       sel_o = status_i[`ST_THERMAL];
            `FN_BRAKE_REL:     sel_o = status_i[`ST_BRAKE_REL];
            `FN_BRAKE_ERR:     sel_o = status_i[`ST_BRAKE_ERR];
            `FN_ZERO_SPEED:    sel_o = status_i[`ST_ZERO_SPEED];
            `FN_SPEED_DEV:     sel_o = status_i[`ST_SPEED_DEV];
            `FN_POS_DONE:      sel_o = status_i[`ST_POS_DONE];
            `FN_FREQ_OVER2:    sel_o = status_i[`ST_FREQ_OVER2];
            `FN_FREQ_REACH2:   sel_o = status_i[`ST_FREQ_REACH2];
            `FN_OVERLOAD2:     sel_o = status_i[`ST_OVERLOAD2];
            `FN_PID_FB_CMP:    sel_o = status_i[`ST_PID_FB_CMP];
            `FN_COMM_LOST:     sel_o = status_i[`ST_COMM_LOST];
            `FN_CAP_LIFE:      sel_o = status_i[`ST_CAP_LIFE];
            `FN_FAN_DROP:      sel_o = status_i[`ST_FAN_DROP];
            `FN_START_CONTACT: sel_o = status_i[`ST_START_CONTACT];
            `FN_HEATSINK_HOT:  sel_o = status_i[`ST_HEATSINK_HOT];
            `FN_LOW_CURRENT:   sel_o = status_i[`ST_LOW_CURRENT];
            `FN_DRIVE_READY:   sel_o = status_i[`ST_DRIVE_READY];
            `FN_FWD_ROT:       sel_o = status_i[`ST_FWD_ROT];
            `FN_REV_ROT:       sel_o = status_i[`ST_REV_ROT];
            `FN_MAJOR_FAIL:    sel_o = status_i[`ST_MAJOR_FAIL];
            default:
            begin
                // Ranges: three analog losses, six logic results, six general outputs
                if (func_i >= `FN_ANALOG_LOST0 && func_i <= `FN_ANALOG_LOST2)
                    sel_o = status_i[`ST_ANALOG_LOST0 + func_i - `FN_ANALOG_LOST0];
                else if (func_i >= `FN_LOGIC_FIRST && func_i <= `FN_LOGIC_LAST)
                    sel_o = status_i[`ST_LOGIC0 + func_i - `FN_LOGIC_FIRST];
                else if (func_i >= `FN_GENOUT_FIRST && func_i <= `FN_GENOUT_LAST)
                    sel_o = status_i[`ST_GENOUT0 + func_i - `FN_GENOUT_FIRST];
                else
                    sel_o = 1'b0;
            end
        endcase
    end

endmodule

// file: src/output_terminal_function_router.v
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "out_router_defs.vh"

module output_terminal_function_router
#(
    parameter NUM_TERM = 5
)
(
    // Clock and reset
    input  wire                     clock_i,
    input  wire                     rst_n_i,
    // APB slave
    input  wire                     psel_i,
    input  wire                     penable_i,
    input  wire                     pwrite_i,
    input  wire [11:0]              paddr_i,
    input  wire [31:0]              pwdata_i,
    output reg  [31:0]              prdata_o,
    output reg                      pready_o,
    output reg                      pslverr_o,
    // Drive status, same clock domain
    input  wire [`ST_WIDTH-1:0]     status_i,
    input  wire                     dc_braking_i,
    input  wire [3:0]               alarm_code_i,
    // Outputs: high means conducting or energised
    output reg  [NUM_TERM-1:0]      term_conduct_o,
    output reg                      relay_energise_o
);

    reg  [7:0]              term_func [0:NUM_TERM-1];
    reg  [7:0]              term_act  [0:NUM_TERM-1];
    reg  [7:0]              relay_func;
    reg  [7:0]              relay_act;
    reg  [7:0]              alarm_code_mode;
    reg  [`ST_WIDTH-1:0]    status_eff;
    reg  [NUM_TERM-1:0]     next_term;
    reg                     next_relay;
    reg  [31:0]             rd_mux;
    reg                     rd_hit;
    wire [NUM_TERM:0]       routed;
    integer                 i;
    integer                 j;

    // Word index of an address within a block of per-terminal registers
    function [2:0] word_idx;
        input [11:0] addr;
        input [11:0] base;
        reg   [11:0] diff;
        begin
            diff     = addr - base;
            word_idx = diff[4:2];
        end
    endfunction

    // Apply active state to a routed flag
    function apply_act;
        input       flag;
        input [7:0] act;
        begin
            if (act == `ACT_NC)
                apply_act = ~flag;
            else
                apply_act = flag;
        end
    endfunction

    // Store only at the taking edge, and never for a misaligned address that gets pslverr
    wire wr_en = psel_i & penable_i & pwrite_i & ~pready_o & (paddr_i[1:0] == 2'h0);

    // Running flag held on during DC braking
    always @*
    begin
        status_eff = status_i;
        status_eff[`ST_RUN] = status_i[`ST_RUN] | dc_braking_i;
    end

    genvar g;
    generate
        for (g = 0; g <= NUM_TERM; g = g + 1)
        begin : g_sel
            if (g == NUM_TERM)
            begin : g_relay
                signal_selector u_signal_selector
                (
                    .func_i   (relay_func),
                    .status_i (status_eff),
                    .sel_o    (routed[g])
                );
            end
            else
            begin : g_term
                signal_selector u_signal_selector
                (
                    .func_i   (term_func[g]),
                    .status_i (status_eff),
                    .sel_o    (routed[g])
                );
            end
        end
    endgenerate

    always @*
    begin
        for (i = 0; i < NUM_TERM; i = i + 1)
        begin
            next_term[i] = apply_act(routed[i], term_act[i]);
            // Alarm code overrides function selection, still through active state
            if (alarm_code_mode == `ALARM_MODE_3BIT && i < 3)
                next_term[i] = apply_act(alarm_code_i[i], term_act[i]);
            else if (alarm_code_mode == `ALARM_MODE_4BIT && i < 4)
                next_term[i] = apply_act(alarm_code_i[i], term_act[i]);
        end
        // Relay energised is inverse sense: setting 01 energises while deasserted
        next_relay = (relay_act == `ACT_NC) ? ~routed[NUM_TERM] : routed[NUM_TERM];
    end

    // Register file
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (j = 0; j < NUM_TERM; j = j + 1)
            begin
                term_func[j] <= `RST_FUNC;
                term_act[j]  <= `RST_TERM_ACT;
            end
            relay_func      <= `RST_FUNC;
            relay_act       <= `RST_RELAY_ACT;
            alarm_code_mode <= `RST_ALARM_MODE;
        end
        else if (wr_en)
        begin
            if (paddr_i >= `ADDR_TERM_FUNC0 && paddr_i <= `ADDR_TERM_FUNC4)
                term_func[word_idx(paddr_i, `ADDR_TERM_FUNC0)] <= pwdata_i[7:0];
            else if (paddr_i >= `ADDR_TERM_ACT0 && paddr_i <= `ADDR_TERM_ACT4)
                term_act[word_idx(paddr_i, `ADDR_TERM_ACT0)] <= pwdata_i[7:0];
            else if (paddr_i == `ADDR_RELAY_FUNC)
                relay_func <= pwdata_i[7:0];
            else if (paddr_i == `ADDR_RELAY_ACT)
                relay_act <= pwdata_i[7:0];
            else if (paddr_i == `ADDR_ALARM_MODE)
                alarm_code_mode <= pwdata_i[7:0];
        end
    end

    // Read decode
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        if (paddr_i[1:0] != 2'h0)
            rd_hit = 1'b0;
        else if (paddr_i >= `ADDR_TERM_FUNC0 && paddr_i <= `ADDR_TERM_FUNC4)
            rd_mux[7:0] = term_func[word_idx(paddr_i, `ADDR_TERM_FUNC0)];
        else if (paddr_i >= `ADDR_TERM_ACT0 && paddr_i <= `ADDR_TERM_ACT4)
            rd_mux[7:0] = term_act[word_idx(paddr_i, `ADDR_TERM_ACT0)];
        else if (paddr_i == `ADDR_RELAY_FUNC)
            rd_mux[7:0] = relay_func;
        else if (paddr_i == `ADDR_RELAY_ACT)
            rd_mux[7:0] = relay_act;
        else if (paddr_i == `ADDR_ALARM_MODE)
            rd_mux[7:0] = alarm_code_mode;
        else if (paddr_i == `ADDR_STATUS)
            rd_mux[NUM_TERM:0] = routed;
        else if (paddr_i == `ADDR_OUTPUTS)
            rd_mux[NUM_TERM:0] = {relay_energise_o, term_conduct_o};
        else
            rd_hit = 1'b0;
    end

    // APB answer: one wait state, so pready and data come from flops
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end
        else if (psel_i && penable_i && !pready_o)
        begin
            pready_o  <= 1'b1;
            prdata_o  <= pwrite_i ? 32'h00000000 : rd_mux;
            pslverr_o <= ~rd_hit;
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // Outputs registered; relay resets de-energised as when unpowered
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            term_conduct_o   <= {NUM_TERM{1'b0}};
            relay_energise_o <= 1'b0;
        end
        else
        begin
            term_conduct_o   <= next_term;
            relay_energise_o <= next_relay;
        end
    end

endmodule

// file: tb/router_props.sv
`timescale 1ns/100ps
`include "out_router_defs.vh"
module router_props
#(
    parameter NUM_TERM = 5
)
(
    input wire                 clock_i,
    input wire                 rst_n_i,
    input wire                 psel_i,
    input wire                 penable_i,
    input wire                 pwrite_i,
    input wire [11:0]          paddr_i,
    input wire [31:0]          pwdata_i,
    input wire [31:0]          prdata_o,
    input wire                 pready_o,
    input wire                 pslverr_o,
    input wire [`ST_WIDTH-1:0] status_i,
    input wire                 dc_braking_i,
    input wire [3:0]           alarm_code_i,
    input wire [NUM_TERM-1:0]  term_conduct_o,
    input wire                 relay_energise_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_acc;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_quiet;
        rst_n_i && $stable(status_i) && $stable(alarm_code_i) && $stable(dc_braking_i)
            && !psel_i;
    endsequence
    property p_wait; s_acc |=> pready_o; endproperty
    property p_pulse; pready_o |=> !pready_o; endproperty
    property p_cause; pready_o |-> $past(psel_i && penable_i); endproperty
    property p_errpair; pslverr_o |-> pready_o; endproperty
    property p_misalign; s_acc ##0 paddr_i[1:0] != 2'b00 |=> pslverr_o; endproperty
    property p_high; s_acc ##0 paddr_i > 12'h038 |=> pslverr_o && prdata_o == 32'h0;
    endproperty
    property p_rowr;
        s_acc ##0 pwrite_i && paddr_i >= 12'h034 && paddr_i <= 12'h038 && paddr_i[1:0] == 2'b00
            |=> !pslverr_o && prdata_o == 32'h0;
    endproperty
    property p_okmap;
        s_acc ##0 paddr_i <= 12'h038 && paddr_i[1:0] == 2'b00
            |=> !pslverr_o && prdata_o[31:8] == 24'h0;
    endproperty
    property p_hold;
        s_quiet [*2] |=> $stable(term_conduct_o) && $stable(relay_energise_o);
    endproperty
    a_wait: assert property (p_wait) else $error("no ready after access");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_cause: assert property (p_cause) else $error("ready without access");
    a_errpair: assert property (p_errpair) else $error("error without ready");
    a_misalign: assert property (p_misalign) else $error("misaligned not refused");
    a_high: assert property (p_high) else $error("unmapped not refused");
    a_rowr: assert property (p_rowr) else $error("read-only write not answered cleanly");
    a_okmap: assert property (p_okmap) else $error("mapped access refused");
    a_hold: assert property (p_hold) else $error("outputs moved on quiet inputs");
endmodule
bind output_terminal_function_router router_props #(.NUM_TERM(NUM_TERM)) u_router_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .status_i(status_i),
    .dc_braking_i(dc_braking_i), .alarm_code_i(alarm_code_i),
    .term_conduct_o(term_conduct_o), .relay_energise_o(relay_energise_o));

// file: tb/load_bank.sv
`timescale 1ns/100ps
module load_bank
#(
    parameter NUM_TERM = 5
)
(
    input  wire [NUM_TERM-1:0] term_conduct_i,
    input  wire                relay_energise_i,
    output wire [NUM_TERM-1:0] input_level_o,
    output wire                primary_closed_o
);
    // Pulled-up controller inputs read low while a terminal conducts
    assign input_level_o = ~term_conduct_i;
    assign primary_closed_o = relay_energise_i;
endmodule

// file: tb/output_terminal_function_router_tb.sv
`timescale 1ns/100ps
`include "out_router_defs.vh"
module output_terminal_function_router_tb;
    logic                 clock = 0;
    logic                 rst_n = 0;
    logic                 psel = 0;
    logic                 penable = 0;
    logic                 pwrite = 0;
    logic [11:0]          paddr = 0;
    logic [31:0]          pwdata = 0;
    logic [`ST_WIDTH-1:0] status = 0;
    logic                 dc_braking = 0;
    logic [3:0]           alarm_code = 0;
    wire  [31:0]          prdata;
    wire                  pready;
    wire                  pslverr;
    wire  [4:0]           term_conduct;
    wire                  relay_energise;
    wire  [4:0]           input_level;
    wire                  primary_closed;
    int                   miscompares = 0;
    int                   checks_done = 0;
    logic [31:0]          rd;
    logic                 er;
    int                   k;
    logic                 r;

    always #5 clock = ~clock;

    output_terminal_function_router u_output_terminal_function_router (
        .clock_i(clock), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .status_i(status),
        .dc_braking_i(dc_braking), .alarm_code_i(alarm_code),
        .term_conduct_o(term_conduct), .relay_energise_o(relay_energise));
    load_bank u_load_bank (.term_conduct_i(term_conduct), .relay_energise_i(relay_energise),
        .input_level_o(input_level), .primary_closed_o(primary_closed));

    task end_of_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
        end
    endtask

    task chk_out(input logic [5:0] exp);
        checks_done++;
        if ({primary_closed, ~input_level} !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t out %b exp %b", $time, {primary_closed, ~input_level}, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            $display("[FAIL] %0t bus timeout", $time);
            miscompares++;
            end_of_test;
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    task set_all(input logic [11:0] base, input logic [7:0] v);
        for (int i = 0; i < 6; i++)
            apb(1, base + 12'(4 * i), {24'h0, v});
    endtask

    // Inputs settle, then three edges cover the registered output
    task drive(input logic [`ST_WIDTH-1:0] st, input logic dc, input logic [3:0] ac);
        @(posedge clock);
        status <= st;
        dc_braking <= dc;
        alarm_code <= ac;
        repeat (3) @(posedge clock);
    endtask

    function int idx(input int c);
        if (c <= 13) return c;
        if (c >= 19 && c <= 29) return c - 5;
        if (c >= 31 && c <= 53) return c - 6;
        return -1;
    endfunction

    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1;
        apb(0, `ADDR_RELAY_ACT, 0); chk(rd, 32'h1);
        apb(0, `ADDR_TERM_ACT4, 0); chk(rd, 32'h0);
        apb(0, `ADDR_TERM_FUNC0, 0); chk(rd, 32'h0);
        chk_out(6'h20);
        apb(0, 12'h03c, 0); chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(0, 12'h002, 0); chk({31'h0, er}, 32'h1);
        apb(1, `ADDR_OUTPUTS, 1); chk({31'h0, er}, 32'h0);
        apb(0, `ADDR_OUTPUTS, 0); chk(rd, 32'h20);
        apb(0, `ADDR_STATUS, 0); chk(rd, 32'h0);
        apb(1, `ADDR_TERM_FUNC4, 32'hffffff2b);
        apb(0, `ADDR_TERM_FUNC4, 0); chk(rd, 32'h2b);
        $display("test registers done");
        for (int c = 0; c < 56; c++)
        begin
            set_all(`ADDR_TERM_FUNC0, 8'(c));
            k = idx(c);
            for (int f = 0; f < 2; f++)
            begin
                if (k < 0)
                    drive(f ? '1 : '0, 0, 0);
                else
                    drive(f ? (48'h1 << k) : ~(48'h1 << k), 0, 0);
                r = (k >= 0) && f;
                chk_out({~r, {5{r}}});
            end
        end
        $display("test codes done");
        set_all(`ADDR_TERM_FUNC0, `FN_FAULT);
        for (int a = 0; a < 2; a++)
        begin
            set_all(`ADDR_TERM_ACT0, 8'(a));
            for (int f = 0; f < 2; f++)
            begin
                drive(48'(f) << `ST_FAULT, 0, 0);
                r = f ^ a;
                chk_out({6{r}});
            end
        end
        $display("test polarity done");
        set_all(`ADDR_TERM_ACT0, `ACT_NO);
        apb(1, `ADDR_ALARM_MODE, `ALARM_MODE_3BIT);
        drive(48'h1 << `ST_FAULT, 0, 4'h5);
        chk_out(6'h3d);
        apb(1, `ADDR_ALARM_MODE, `ALARM_MODE_4BIT);
        drive(48'h1 << `ST_FAULT, 0, 4'ha);
        chk_out(6'h3a);
        apb(1, `ADDR_ALARM_MODE, `ALARM_MODE_OFF);
        drive(48'h1 << `ST_FAULT, 0, 4'ha);
        chk_out(6'h3f);
        $display("test alarm code done");
        set_all(`ADDR_TERM_FUNC0, `FN_RUN);
        drive(0, 1, 0);
        chk_out(6'h3f);
        drive(0, 0, 0);
        chk_out(6'h00);
        $display("test braking done");
        end_of_test;
    end
endmodule
